// [rtl/system_control_registers.v]
// system control and serial timer control registers with ahb-lite access
// Overview of operation
// (RULE1) In extended mode with the wide-area bit set, the chip select goes low for f80000-fbffff.
// (RULE2) In extended mode with the io strobe bit clear, the strobe goes low on any external access.
// (RULE3) With the io strobe bit set, the strobe goes low only for fff000-fff7ff.
// (RULE4) The interrupt mode field picks mode 0 or 1; its upper bit is read-only zero.
// (RULE5) The reset source flag reads 0 after a watchdog reset and 1 after an external one.
// (RULE6) The nmi edge bit picks a falling edge when 0 and a rising edge when 1.
// (RULE7) With the keypad window bit clear, the shared window reaches the two aux timers.
// (RULE8) With the keypad window bit set, the shared window reaches the keypad registers.
// (RULE9) The ram enable bit disables on-chip ram when 0 and enables it when 1.
// (RULE10) The ram enable bit returns to 1 whenever reset is applied.
// (RULE11) The top three serial timer bits each set the i2c rate extension of one channel.
// (RULE12) External pin functions apply only once software sets the extended mode bit.
// (RULE13) Writes to the read-only flag and upper mode bit are dropped; reads show them.
`timescale 1ns/1ps
`include "sysctl_consts.vh"

module system_control_registers #(
    parameter ADDR_W = 24
)(
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg hreadyout,
    output reg [31:0] hrdata,
    output reg hresp,
    input wire wdt_reset_cause,
    input wire [ADDR_W-1:0] cpu_addr,
    input wire cpu_access,
    input wire cpu_ext_access,
    input wire nmi_in,
    output reg nmi_request,
    output reg wide_area_chip_select_n,
    output reg wait_pin_function,
    output reg external_access_strobe_n,
    output reg io_strobe_mode,
    output reg aux_timer_window_sel,
    output reg keypad_window_sel,
    output reg onchip_ram_enable,
    output reg [1:0] irq_ctrl_mode,
    output reg [2:0] i2c_rate_ext
);

    // register bits
    reg wide_area_select_enable_q;
    reg io_strobe_enable_q;
    reg irq_ctrl_mode_lo_q;
    reg reset_source_flag_q;
    reg nonmask_irq_edge_select_q;
    reg keypad_window_select_q;
    reg onchip_ram_enable_q;
    reg [2:0] i2c_rate_ext_q;
    reg extended_mode_enable_q;

    // bus pipeline state, reset cause capture flag and nmi edge history
    reg wr_pend_q;
    reg rd_pend_q;
    reg [7:0] addr_q;
    reg src_captured_q;
    reg nmi_prev_q;

    // decoder outputs
    wire in_wide_area;
    wire in_io_area;
    wire in_shared_window;

    wire addr_phase;
    wire [7:0] sysctl_value;
    wire [7:0] stctl_value;
    wire [7:0] mode_value;
    reg [7:0] read_mux_d;

    // word-aligned register match, upper address bits left to hsel
    function reg_hit;
        input [7:0] addr;
        input [7:0] ofs;
        begin
            reg_hit = (addr[7:2] == ofs[7:2]);
        end
    endfunction

    address_window_decode #(
        .ADDR_W(ADDR_W)
    ) u_decode (
        .cpu_addr(cpu_addr),
        .in_wide_area(in_wide_area),
        .in_io_area(in_io_area),
        .in_shared_window(in_shared_window)
    );

    // a transfer is taken only when the bus is ready and nonseq/seq
    assign addr_phase = hsel && hready && htrans[`HTRANS_NONSEQ_BIT];

    // register images as software reads them
    assign sysctl_value = {wide_area_select_enable_q,
                           io_strobe_enable_q,
                           `RST_CLEAR_BIT, // RULE4
                           irq_ctrl_mode_lo_q,
                           reset_source_flag_q, // RULE13
                           nonmask_irq_edge_select_q,
                           keypad_window_select_q,
                           onchip_ram_enable_q};
    // low serial timer bits belong to other blocks and read zero here
    assign stctl_value = {i2c_rate_ext_q, 5'h00};
    assign mode_value = {7'h00, extended_mode_enable_q};

    // read data select, unmapped offsets read zero
    always @*
    begin
        read_mux_d = 8'h00;
        if (reg_hit(addr_q, `OFS_SYSTEM_CONTROL))
            read_mux_d = sysctl_value;
        else if (reg_hit(addr_q, `OFS_SERIAL_TIMER_CONTROL))
            read_mux_d = stctl_value;
        else if (reg_hit(addr_q, `OFS_MODE_ENABLE))
            read_mux_d = mode_value;
    end

    // bus slave: writes are zero wait; reads take one wait state so
    // a write in the preceding data phase is already visible
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            addr_q <= 8'h00;
            hreadyout <= 1'b1;
            hrdata <= 32'h00000000;
            hresp <= `HRESP_OKAY;
        end
        else
        begin
            hresp <= `HRESP_OKAY;
            if (rd_pend_q)
            begin
                hrdata <= {24'h000000, read_mux_d};
                hreadyout <= 1'b1;
                rd_pend_q <= 1'b0;
                wr_pend_q <= 1'b0;
            end
            else if (addr_phase)
            begin
                addr_q <= haddr[7:0];
                wr_pend_q <= hwrite;
                rd_pend_q <= !hwrite;
                hreadyout <= hwrite; // read inserts one wait cycle
            end
            else
            begin
                wr_pend_q <= 1'b0;
            end
        end
    end

    // register writes land at the end of the write data phase
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wide_area_select_enable_q <= `RST_CLEAR_BIT;
            io_strobe_enable_q <= `RST_CLEAR_BIT;
            irq_ctrl_mode_lo_q <= `RST_CLEAR_BIT;
            nonmask_irq_edge_select_q <= `RST_CLEAR_BIT;
            keypad_window_select_q <= `RST_CLEAR_BIT;
            onchip_ram_enable_q <= `RST_ONCHIP_RAM_ENABLE; // RULE10
            i2c_rate_ext_q <= 3'h0; // RULE11
            extended_mode_enable_q <= `RST_CLEAR_BIT; // RULE12
        end
        else if (wr_pend_q)
        begin
            if (reg_hit(addr_q, `OFS_SYSTEM_CONTROL))
            begin
                // flag and upper mode bit are not writable
                wide_area_select_enable_q <= hwdata[`BIT_WIDE_AREA_SELECT_ENABLE];
                io_strobe_enable_q <= hwdata[`BIT_IO_STROBE_ENABLE];
                irq_ctrl_mode_lo_q <= hwdata[`BIT_IRQ_CTRL_MODE_LO]; // RULE13
                nonmask_irq_edge_select_q <= hwdata[`BIT_NONMASK_IRQ_EDGE_SELECT];
                keypad_window_select_q <= hwdata[`BIT_KEYPAD_WINDOW_SELECT];
                onchip_ram_enable_q <= hwdata[`BIT_ONCHIP_RAM_ENABLE]; // RULE9
            end
            if (reg_hit(addr_q, `OFS_SERIAL_TIMER_CONTROL))
                i2c_rate_ext_q <= hwdata[`BIT_I2C_RATE_EXT_CH2:`BIT_I2C_RATE_EXT_CH0]; // RULE11
            if (reg_hit(addr_q, `OFS_MODE_ENABLE))
                extended_mode_enable_q <= hwdata[`BIT_EXTENDED_MODE_ENABLE]; // RULE12
        end
    end

    // reset cause strap caught on the first edge after release, since an
    // asynchronous reset may only load constants
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            reset_source_flag_q <= `RST_RESET_SOURCE_FLAG; // RULE5
            src_captured_q <= 1'b0;
        end
        else if (!src_captured_q)
        begin
            reset_source_flag_q <= !wdt_reset_cause; // RULE5
            src_captured_q <= 1'b1;
        end
    end

    // nmi edge detector; input is already synchronous to hclk
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            nmi_prev_q <= 1'b0;
            nmi_request <= 1'b0;
        end
        else
        begin
            nmi_prev_q <= nmi_in;
            if (nonmask_irq_edge_select_q)
                nmi_request <= nmi_in && !nmi_prev_q; // RULE6
            else
                nmi_request <= !nmi_in && nmi_prev_q; // RULE6
        end
    end

    // external pin functions; chip select and strobe idle high in single-chip mode so no
    // stray strobe appears before software enables extended mode
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wide_area_chip_select_n <= 1'b1;
            wait_pin_function <= 1'b0;
            external_access_strobe_n <= 1'b1;
            io_strobe_mode <= 1'b0;
        end
        else
        begin
            wide_area_chip_select_n <= !(extended_mode_enable_q // RULE12
                && wide_area_select_enable_q && cpu_ext_access && in_wide_area); // RULE1
            wait_pin_function <= extended_mode_enable_q && !wide_area_select_enable_q; // RULE1
            io_strobe_mode <= extended_mode_enable_q && io_strobe_enable_q;
            if (!extended_mode_enable_q)
                external_access_strobe_n <= 1'b1; // RULE12
            else if (io_strobe_enable_q)
                external_access_strobe_n <= !(cpu_ext_access && in_io_area); // RULE3
            else
                external_access_strobe_n <= !cpu_ext_access; // RULE2
        end
    end

    // shared window steering and plain control outputs
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            aux_timer_window_sel <= 1'b0;
            keypad_window_sel <= 1'b0;
            onchip_ram_enable <= `RST_ONCHIP_RAM_ENABLE;
            irq_ctrl_mode <= 2'h0;
            i2c_rate_ext <= 3'h0;
        end
        else
        begin
            aux_timer_window_sel <= cpu_access && in_shared_window
                && !keypad_window_select_q; // RULE7
            keypad_window_sel <= cpu_access && in_shared_window
                && keypad_window_select_q; // RULE8
            onchip_ram_enable <= onchip_ram_enable_q; // RULE9
            irq_ctrl_mode <= {`RST_CLEAR_BIT, irq_ctrl_mode_lo_q}; // RULE4
            i2c_rate_ext <= i2c_rate_ext_q; // RULE11
        end
    end

    // hsize is accepted but only whole-word transfers are expected
    wire unused_size = |hsize;

endmodule

// [rtl/sysctl_consts.vh]
// constants for the system control register block
`ifndef SYSCTL_CONSTS_VH
`define SYSCTL_CONSTS_VH

// register byte offsets on the bus
`define OFS_SYSTEM_CONTROL 8'h00
`define OFS_SERIAL_TIMER_CONTROL 8'h04
`define OFS_MODE_ENABLE 8'h08

// system_control bit positions
`define BIT_WIDE_AREA_SELECT_ENABLE 7
`define BIT_IO_STROBE_ENABLE 6
`define BIT_IRQ_CTRL_MODE_HI 5
`define BIT_IRQ_CTRL_MODE_LO 4
`define BIT_RESET_SOURCE_FLAG 3
`define BIT_NONMASK_IRQ_EDGE_SELECT 2
`define BIT_KEYPAD_WINDOW_SELECT 1
`define BIT_ONCHIP_RAM_ENABLE 0

// serial_timer_control bit positions
`define BIT_I2C_RATE_EXT_CH2 7
`define BIT_I2C_RATE_EXT_CH0 5

// mode_enable bit position
`define BIT_EXTENDED_MODE_ENABLE 0

// reset values of single bits
`define RST_RESET_SOURCE_FLAG 1'b1
`define RST_ONCHIP_RAM_ENABLE 1'b1
`define RST_CLEAR_BIT 1'b0

// cpu address regions, 24-bit addresses
`define WIDE_AREA_LO 24'hf80000
`define WIDE_AREA_HI 24'hfbffff
`define IO_AREA_LO 24'hfff000
`define IO_AREA_HI 24'hfff7ff
`define SHARED_WIN_A_LO 24'hfffff0
`define SHARED_WIN_A_HI 24'hfffff7
`define SHARED_WIN_B_LO 24'hfffffc
`define SHARED_WIN_B_HI 24'hffffff

// bus encodings
`define HTRANS_NONSEQ_BIT 1
`define HRESP_OKAY 1'b0

`endif

// [rtl/address_window_decode.v]
// cpu address region decoder for the external pins and shared window
`timescale 1ns/1ps
`include "sysctl_consts.vh"

module address_window_decode #(
    parameter ADDR_W = 24
)(
    input wire [ADDR_W-1:0] cpu_addr,
    output wire in_wide_area,
    output wire in_io_area,
    output wire in_shared_window
);

    // inclusive range check, shared by every region
    function in_range;
        input [ADDR_W-1:0] addr;
        input [ADDR_W-1:0] lo;
        input [ADDR_W-1:0] hi;
        begin
            in_range = (addr >= lo) && (addr <= hi);
        end
    endfunction

    // 256-kbyte expansion area behind the wide chip select
    assign in_wide_area = in_range(cpu_addr, `WIDE_AREA_LO, `WIDE_AREA_HI);

    // i/o expansion area behind the io strobe
    assign in_io_area = in_range(cpu_addr, `IO_AREA_LO, `IO_AREA_HI);

    // two slices shared between timers and keypad control
    assign in_shared_window = in_range(cpu_addr, `SHARED_WIN_A_LO, `SHARED_WIN_A_HI)
        || in_range(cpu_addr, `SHARED_WIN_B_LO, `SHARED_WIN_B_HI);

endmodule

// [verification/system_control_registers_sva.sv]
// concurrent checks on the system control register block ports
`timescale 1ns/1ps
module system_control_registers_sva #(
    parameter ADDR_W = 24
)(
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire hready,
    input wire hreadyout,
    input wire hresp,
    input wire [ADDR_W-1:0] cpu_addr,
    input wire cpu_access,
    input wire cpu_ext_access,
    input wire nmi_request,
    input wire wide_area_chip_select_n,
    input wire wait_pin_function,
    input wire external_access_strobe_n,
    input wire aux_timer_window_sel,
    input wire keypad_window_sel,
    input wire [1:0] irq_ctrl_mode
);
    // region hits, judged on the cycle before the pins move
    wire in_wide = cpu_addr >= 24'hf80000 && cpu_addr <= 24'hfbffff;
    wire in_win = (cpu_addr >= 24'hfffff0 && cpu_addr <= 24'hfffff7) || cpu_addr >= 24'hfffffc;
    wire take = hsel && hready && htrans[1];
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    chk_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read data phase not exactly one wait");
    chk_write_zero: assert property (take && hwrite |=> hreadyout)
        else $error("write data phase stalled");
    chk_resp_okay: assert property (hresp == 1'b0)
        else $error("response not okay");
    chk_cs_cause: assert property (!wide_area_chip_select_n |-> $past(cpu_ext_access) && $past(in_wide))
        else $error("chip select low outside wide area");
    chk_wait_excl: assert property (wait_pin_function |-> wide_area_chip_select_n)
        else $error("chip select low in wait pin function");
    chk_strobe_cause: assert property (!external_access_strobe_n |-> $past(cpu_ext_access))
        else $error("strobe low without external access");
    chk_mode_hi: assert property (irq_ctrl_mode[1] == 1'b0)
        else $error("upper interrupt mode bit set");
    chk_win_cause: assert property (aux_timer_window_sel || keypad_window_sel |-> $past(cpu_access) && $past(in_win))
        else $error("window steering outside shared window");
    chk_win_excl: assert property (!(aux_timer_window_sel && keypad_window_sel))
        else $error("both window targets selected");
    chk_nmi_pulse: assert property (nmi_request |=> !nmi_request)
        else $error("nmi request longer than one cycle");
endmodule

bind system_control_registers system_control_registers_sva #(.ADDR_W(ADDR_W)) u_sva (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .cpu_addr(cpu_addr),
    .cpu_access(cpu_access), .cpu_ext_access(cpu_ext_access), .nmi_request(nmi_request),
    .wide_area_chip_select_n(wide_area_chip_select_n), .wait_pin_function(wait_pin_function),
    .external_access_strobe_n(external_access_strobe_n),
    .aux_timer_window_sel(aux_timer_window_sel), .keypad_window_sel(keypad_window_sel),
    .irq_ctrl_mode(irq_ctrl_mode)
);

// [verification/tb_system_control_registers.sv]
// self-checking bench for the system control register block
`timescale 1ns/1ps
module tb_system_control_registers;
    typedef struct packed {logic [7:0] sys; logic [2:0] ctl; logic [23:0] a; logic [3:0] ex;} row_t;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic wdt_cause = 1'b0;
    logic [23:0] cpu_addr = 24'h0;
    logic cpu_access = 1'b0;
    logic cpu_ext_access = 1'b0;
    logic nmi_in = 1'b0;
    wire hreadyout, hresp, nmi_request, cs_n, as_n, wait_fn, aux_sel, kp_sel, ram_en, io_mode;
    wire [31:0] hrdata;
    wire [1:0] irq_mode;
    wire [2:0] rate;
    // pin outputs gathered into one word for comparison
    wire [31:0] pins = {20'h0, cs_n, as_n, aux_sel, kp_sel, wait_fn, ram_en, irq_mode, io_mode, rate};
    int err_total = 0;
    int n_tests = 0;
    logic [31:0] rd;
    row_t rows [13];
    always #50 hclk = ~hclk;
    system_control_registers dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .wdt_reset_cause(wdt_cause),
        .cpu_addr(cpu_addr), .cpu_access(cpu_access), .cpu_ext_access(cpu_ext_access),
        .nmi_in(nmi_in), .nmi_request(nmi_request), .wide_area_chip_select_n(cs_n),
        .wait_pin_function(wait_fn), .external_access_strobe_n(as_n), .io_strobe_mode(io_mode),
        .aux_timer_window_sel(aux_sel), .keypad_window_sel(kp_sel), .onchip_ram_enable(ram_en),
        .irq_ctrl_mode(irq_mode), .i2c_rate_ext(rate)
    );
    task automatic end_of_test;
        begin
            if (err_total == 0 && n_tests > 0)
                $display("NO MISMATCHES");
            else
                $display("MISMATCHES SEEN");
            $finish;
        end
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        begin
            n_tests++;
            if (got !== exp)
            begin
                $display("ERROR %0t got %h expected %h", $time, got, exp);
                err_total++;
            end
        end
    endtask
    // bounded wait for hready; a hang ends the run
    task automatic wait_rdy;
        int i;
        begin
            i = 0;
            @(posedge hclk);
            while (hreadyout !== 1'b1 && i < 20)
            begin
                @(posedge hclk);
                i++;
            end
            if (i >= 20)
            begin
                $display("ERROR %0t bus wait timed out", $time);
                err_total++;
                end_of_test;
            end
        end
    endtask
    // one single word transfer, address phase then data phase
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        begin
            haddr <= {24'h0, a};
            htrans <= 2'h2;
            hwrite <= w;
            hsel <= 1'b1;
            wait_rdy;
            htrans <= 2'h0;
            hsel <= 1'b0;
            hwdata <= {24'h0, d};
            wait_rdy;
            rd = hrdata;
        end
    endtask
    // counts nmi pulses over four cycles
    task automatic count_nmi(input int exp);
        int c;
        begin
            c = 0;
            repeat (4)
            begin
                @(posedge hclk);
                if (nmi_request === 1'b1)
                    c++;
            end
            chk(c, exp);
        end
    endtask
    // wdt cause held steady across release, since it is captured after it
    task automatic rst(input logic w);
        begin
            wdt_cause <= w;
            hresetn <= 1'b0;
            repeat (20) @(posedge hclk);
            hresetn <= 1'b1;
            @(posedge hclk);
        end
    endtask
    // row: register byte, {ext mode, ext access, cpu access}, address, {cs, strobe, aux, kp}
    initial
    begin
        int k;
        rows[0] = '{8'h81, 3'h7, 24'hf80000, 4'h0};
        rows[1] = '{8'h81, 3'h7, 24'hfbffff, 4'h0};
        rows[2] = '{8'h90, 3'h7, 24'hfc0000, 4'h8};
        rows[3] = '{8'h01, 3'h7, 24'hf80010, 4'h8};
        rows[4] = '{8'hc1, 3'h7, 24'hfff000, 4'h8};
        rows[5] = '{8'hc1, 3'h7, 24'hfff7ff, 4'h8};
        rows[6] = '{8'hc1, 3'h7, 24'hfff800, 4'hc};
        rows[7] = '{8'hc1, 3'h3, 24'hf80000, 4'hc};
        rows[8] = '{8'h01, 3'h5, 24'hfffff0, 4'he};
        rows[9] = '{8'h03, 3'h5, 24'hfffff7, 4'hd};
        rows[10] = '{8'h03, 3'h5, 24'hfffffc, 4'hd};
        rows[11] = '{8'h01, 3'h5, 24'hfffff8, 4'hc};
        rows[12] = '{8'hab, 3'h5, 24'hffffff, 4'hd};
        rst(1'b0);
        chk(pins, 32'hc40);
        bus(1'b0, 8'h00, 8'h00);
        chk(rd, 32'h09);
        for (k = 0; k < 13; k++)
        begin
            bus(1'b1, 8'h08, {7'h0, rows[k].ctl[2]});
            bus(1'b1, 8'h00, rows[k].sys);
            {cpu_ext_access, cpu_access} <= rows[k].ctl[1:0];
            cpu_addr <= rows[k].a;
            repeat (3) @(posedge hclk);
            chk(pins, {20'h0, rows[k].ex, rows[k].ctl[2] & ~rows[k].sys[7], rows[k].sys[0], 1'b0, rows[k].sys[4], rows[k].ctl[2] & rows[k].sys[6], 3'h0});
            bus(1'b0, 8'h00, 8'h00);
            chk(rd, {24'h0, rows[k].sys & 8'hd7 | 8'h08});
        end
        for (k = 0; k < 3; k++)
        begin
            bus(1'b1, 8'h04, 8'h20 << k);
            repeat (2) @(posedge hclk);
            chk(pins & 32'h7, 32'h1 << k);
            bus(1'b0, 8'h04, 8'h00);
            chk(rd, 32'h20 << k);
        end
        bus(1'b1, 8'h04, 8'hff);
        bus(1'b0, 8'h04, 8'h00);
        chk(rd, 32'he0);
        bus(1'b1, 8'h0c, 8'hff);
        bus(1'b0, 8'h0c, 8'h00);
        chk(rd, 32'h0);
        for (k = 0; k < 2; k++)
        begin
            bus(1'b1, 8'h00, {5'h0, k[0], 2'h1});
            nmi_in <= ~k[0];
            repeat (4) @(posedge hclk);
            nmi_in <= k[0];
            count_nmi(1);
            nmi_in <= ~k[0];
            count_nmi(0);
        end
        bus(1'b1, 8'h00, 8'h00);
        rst(1'b1);
        bus(1'b0, 8'h00, 8'h00);
        chk(rd, 32'h01);
        rst(1'b0);
        bus(1'b0, 8'h00, 8'h00);
        chk(rd, 32'h09);
        end_of_test;
    end
endmodule
